// [logic/charge_pkg.sv]
// shared constants, types and helpers of the charge phase controller
package charge_pkg;

   // ------------------------------------------------------------------
   // time base
   // ------------------------------------------------------------------
   localparam int CLK_NS        = 4;
   localparam int SEC_NS        = 1000000000;
   localparam int SEC_CYC       = SEC_NS / CLK_NS;
   localparam int PULSE_ON_US   = 286;
   localparam int TOPOFF_OFF_US = 4290;
   localparam int TRK_LONG_US   = 72900;
   localparam int TRK_SHORT_US  = 17900;
   // least time rounds up, off times round down
   localparam int PULSE_ON_CYC  = (PULSE_ON_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int TOPOFF_OFF_CYC = (TOPOFF_OFF_US * 1000) / CLK_NS;
   localparam int TRK_LONG_CYC  = (TRK_LONG_US * 1000) / CLK_NS;
   localparam int TRK_SHORT_CYC = (TRK_SHORT_US * 1000) / CLK_NS;
   localparam int SAMPLE_S      = 19;
   localparam int LIMIT_LOW_MIN  = 80;
   localparam int LIMIT_MID_MIN  = 320;
   localparam int LIMIT_HIGH_MIN = 40;
   localparam int LIMIT_LOW_S    = LIMIT_LOW_MIN * 60;
   localparam int LIMIT_MID_S    = LIMIT_MID_MIN * 60;
   localparam int LIMIT_HIGH_S   = LIMIT_HIGH_MIN * 60;
   localparam int SLOPE_DROP_LSB = 10;  // 25.6mV at 2.56mV per code

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] TIMER_OFS  = 8'h08;
   localparam int CTRL_RESTART_BIT   = 0;
   localparam int CTRL_NOTOP_BIT     = 1;
   localparam logic CTRL_NOTOP_RESET = 1'b0;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} level_t;
   typedef enum logic [1:0] {PH_PENDING, PH_FAST, PH_TOPOFF, PH_TRICKLE} phase_t;

   // two comparator levels to one of three settings, high wins a tie
   function automatic level_t decode_level(input logic lo, input logic hi);
      if (hi)
      begin
         return LVL_HIGH;
      end
      return lo ? LVL_LOW : LVL_MID;
   endfunction

endpackage

// [logic/pulse_if.sv]
// pulse modulator link between controller and generator
`timescale 1ns/10ps
interface pulse_if;
   logic        run;      // modulator active
   logic [31:0] off_cyc;  // off length in cycles
   logic        gate_on;  // current enabled slot

   modport ctrl (output run, output off_cyc, input gate_on);
   modport gen  (input run, input off_cyc, output gate_on);
endinterface

// [logic/pulse_gen.sv]
// fixed on-time, variable off-time modulator for the charge gate
`timescale 1ns/10ps
module pulse_gen
   import charge_pkg::*;
#(
   parameter int ON_CYC = PULSE_ON_CYC
)(
   input wire logic aclk,     // system clock
   input wire logic aresetn,  // sync reset, low
   pulse_if.gen     p         // modulator link
);

   logic [31:0] cnt;

   // ------------------------------------------------------------------
   // on/off slot counter
   // ------------------------------------------------------------------
   // off compare uses >= so a shorter off length never overruns
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !p.run)
      begin
         cnt       <= 32'h0;
         p.gate_on <= 1'b1;
      end
      else if (p.gate_on)
      begin
         if (cnt == 32'(ON_CYC - 1))
         begin
            cnt       <= 32'h0;
            p.gate_on <= 1'b0;
         end
         else
         begin
            cnt <= cnt + 32'h1;
         end
      end
      else if (cnt >= p.off_cyc - 32'h1)
      begin
         cnt       <= 32'h0;
         p.gate_on <= 1'b1;
      end
      else
      begin
         cnt <= cnt + 32'h1;
      end
   end

   on_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
      p.run && p.gate_on |-> cnt < 32'(ON_CYC))
      else $error("on slot overran");
   off_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
      p.run && $past(p.run) && $stable(p.off_cyc) && !p.gate_on |-> cnt < p.off_cyc)
      else $error("off slot overran");

endmodule

// [logic/charge_phase_ctrl.sv]
// charge phase control with axi4-lite status and control registers
`timescale 1ns/10ps
module charge_phase_ctrl
   import charge_pkg::*;
#(
   parameter bit TOPOFF_VARIANT = 1'b1,
   parameter int SAMPLE_W       = 10,
   parameter int SEC_CYCLES     = SEC_CYC,
   parameter int ON_CYCLES      = PULSE_ON_CYC,
   parameter int TOPOFF_OFF     = TOPOFF_OFF_CYC,
   parameter int TRK_LONG       = TRK_LONG_CYC,
   parameter int TRK_SHORT      = TRK_SHORT_CYC,
   parameter int LIMIT_LOW      = LIMIT_LOW_S,
   parameter int LIMIT_MID      = LIMIT_MID_S,
   parameter int LIMIT_HIGH     = LIMIT_HIGH_S
)(
   input  wire logic                aclk,                // system clock
   input  wire logic                aresetn,             // sync reset, low
   input  wire logic [7:0]          awaddr,              // write address
   input  wire logic                awvalid,             // write address valid
   output logic                     awready,             // write address ready
   input  wire logic [31:0]         wdata,               // write data
   input  wire logic [3:0]          wstrb,               // write byte strobes
   input  wire logic                wvalid,              // write data valid
   output logic                     wready,              // write data ready
   output logic [1:0]               bresp,               // write response
   output logic                     bvalid,              // write response valid
   input  wire logic                bready,              // write response ready
   input  wire logic [7:0]          araddr,              // read address
   input  wire logic                arvalid,             // read address valid
   output logic                     arready,             // read address ready
   output logic [31:0]              rdata,               // read data
   output logic [1:0]               rresp,               // read response
   output logic                     rvalid,              // read data valid
   input  wire logic                rready,              // read data ready
   input  wire logic                option_low,          // option select at low
   input  wire logic                option_high,         // option select at high
   input  wire logic                cell_limit_level,    // cell above limit
   input  wire logic                sleep_threshold,     // cell above sleep level
   input  wire logic                thermal_cutoff_level, // sense below cutoff
   input  wire logic                hot_fault_level,     // sense below hot fault
   input  wire logic                cold_fault_level,    // sense above cold fault
   input  wire logic                charge_suspend,      // inhibit, high
   input  wire logic [SAMPLE_W-1:0] thermistor_sense,    // sampled sense code
   output logic                     charge_current_gate_o,  // pin level, low
   output logic                     charge_current_gate_oe, // pulls low, stops current
   output logic                     status_indicator_n_o,   // pin level, low
   output logic                     status_indicator_n_oe   // pulls indicator low
);

   pulse_if pm ();

   phase_t              phase;
   level_t              level;
   logic                sleep;
   logic                susp_q;
   logic                cell_lim_q;
   logic                new_cycle;
   logic                restart_wr;
   logic                no_topoff;
   logic [31:0]         sec_cnt;
   logic                sec_tick;
   logic [31:0]         charge_secs;
   logic [4:0]          sample_sec;
   logic [SAMPLE_W-1:0] hist [3];
   logic [1:0]          hist_cnt;
   logic                slope_drop;
   logic                aw_held;
   logic                w_held;
   logic [7:0]          waddr;
   logic [31:0]         wdat;
   logic [3:0]          wstr;

   // ------------------------------------------------------------------
   // conditions
   // ------------------------------------------------------------------
   logic        start_ok;
   logic        timeout;
   logic        topoff_ok;
   logic        fast_end;
   logic        topoff_end;
   logic        charging;
   logic        slope_window;
   logic [31:0] limit_s;
   logic        do_write;

   // setting picks limit, top-off and trickle rate together
   always_comb
   begin
      case (level)
         LVL_LOW:  limit_s = 32'(LIMIT_LOW);
         LVL_MID:  limit_s = 32'(LIMIT_MID);
         default:  limit_s = 32'(LIMIT_HIGH);
      endcase
   end

   assign start_ok = !cell_limit_level && !hot_fault_level
                     && !(TOPOFF_VARIANT && cold_fault_level);
   assign timeout    = charge_secs >= limit_s;
   assign topoff_ok  = TOPOFF_VARIANT && level != LVL_HIGH && !no_topoff;
   assign fast_end   = cell_limit_level || thermal_cutoff_level
                       || timeout || slope_drop;
   // slope is deliberately absent from the top-off end set
   assign topoff_end = cell_limit_level || thermal_cutoff_level || timeout;
   assign charging   = (phase == PH_FAST || phase == PH_TOPOFF) && !charge_suspend;
   assign slope_window = !thermal_cutoff_level
                         && !(TOPOFF_VARIANT && cold_fault_level);
   assign do_write   = aw_held && w_held && !bvalid;

   // ------------------------------------------------------------------
   // input registers and cycle start
   // ------------------------------------------------------------------
   // comparators arrive clean, so one register stage is enough
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         level      <= LVL_MID;
         sleep      <= 1'b0;
         susp_q     <= 1'b0;
         cell_lim_q <= 1'b0;
      end
      else
      begin
         level      <= decode_level(option_low, option_high);
         sleep      <= sleep_threshold;
         susp_q     <= charge_suspend;
         cell_lim_q <= cell_limit_level;
      end
   end

   // reset value one stands in for power-up
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         new_cycle <= 1'b1;
      end
      else
      begin
         new_cycle <= (cell_lim_q && !cell_limit_level) || restart_wr;
      end
   end

   // ------------------------------------------------------------------
   // phase machine
   // ------------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         phase <= PH_PENDING;
      end
      else if (sleep)
      begin
         phase <= PH_TRICKLE;
      end
      else if (new_cycle)
      begin
         phase <= start_ok ? PH_FAST : PH_PENDING;
      end
      else if (!charge_suspend)
      begin
         case (phase)
            PH_PENDING:
            begin
               if (start_ok)
               begin
                  phase <= PH_FAST;
               end
            end
            PH_FAST:
            begin
               if (fast_end)
               begin
                  phase <= topoff_ok ? PH_TOPOFF : PH_TRICKLE;
               end
            end
            PH_TOPOFF:
            begin
               if (topoff_end)
               begin
                  phase <= PH_TRICKLE;
               end
            end
            default:
            begin
               phase <= PH_TRICKLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // time base and charge timer
   // ------------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn || sec_cnt == 32'(SEC_CYCLES - 1))
      begin
         sec_cnt <= 32'h0;
      end
      else
      begin
         sec_cnt <= sec_cnt + 32'h1;
      end
   end

   assign sec_tick = sec_cnt == 32'(SEC_CYCLES - 1);

   // timer restarts between fast and top-off; frozen while suspended
   always_ff @(posedge aclk)
   begin
      if (!aresetn || new_cycle || sleep)
      begin
         charge_secs <= 32'h0;
      end
      else if (phase == PH_FAST && !charge_suspend && fast_end)
      begin
         charge_secs <= 32'h0;
      end
      else if (charging && sec_tick && !timeout)
      begin
         charge_secs <= charge_secs + 32'h1;
      end
   end

   // ------------------------------------------------------------------
   // thermistor slope sampling
   // ------------------------------------------------------------------
   // sampling ignores suspend; only the history is dropped
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sample_sec <= 5'h0;
         hist_cnt   <= 2'h0;
         slope_drop <= 1'b0;
         hist       <= '{default: '0};
      end
      else
      begin
         slope_drop <= 1'b0;
         if (sec_tick)
         begin
            sample_sec <= (sample_sec == 5'(SAMPLE_S - 1)) ? 5'h0 : sample_sec + 5'h1;
         end
         if (charge_suspend && !susp_q)
         begin
            hist_cnt <= 2'h0;
         end
         else if (sec_tick && sample_sec == 5'(SAMPLE_S - 1))
         begin
            hist[0] <= thermistor_sense;
            hist[1] <= hist[0];
            hist[2] <= hist[1];
            if (hist_cnt != 2'h3)
            begin
               hist_cnt <= hist_cnt + 2'h1;
            end
            // compare with the sample three back, in the valid window
            if (hist_cnt == 2'h3 && slope_window && hist[2] >= thermistor_sense
                && hist[2] - thermistor_sense >= SAMPLE_W'(SLOPE_DROP_LSB))
            begin
               slope_drop <= 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------------
   assign pm.run     = !sleep && !(phase == PH_FAST && !charge_suspend);
   assign pm.off_cyc = (phase == PH_TOPOFF && !charge_suspend) ? 32'(TOPOFF_OFF)
                       : (level == LVL_MID) ? 32'(TRK_SHORT) : 32'(TRK_LONG);

   pulse_gen #(
      .ON_CYC (ON_CYCLES)
   ) u_pulse (
      .aclk    (aclk),
      .aresetn (aresetn),
      .p       (pm)
   );

   // current flows while the gate floats; pulled low it stops
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         charge_current_gate_oe <= 1'b0;
         charge_current_gate_o  <= 1'b0;
         status_indicator_n_oe  <= 1'b0;
         status_indicator_n_o   <= 1'b0;
      end
      else if (sleep)
      begin
         charge_current_gate_oe <= 1'b0;
         status_indicator_n_oe  <= 1'b0;
      end
      else
      begin
         charge_current_gate_oe <= pm.run && !pm.gate_on;
         if (!charge_suspend)
         begin
            status_indicator_n_oe <= phase == PH_FAST || phase == PH_PENDING;
         end
      end
   end

   // ------------------------------------------------------------------
   // axi4-lite slave
   // ------------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready <= 1'b0;
         wready  <= 1'b0;
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         waddr   <= 8'h0;
         wdat    <= 32'h0;
         wstr    <= 4'h0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            awready <= 1'b0;
            aw_held <= 1'b1;
            waddr   <= awaddr;
         end
         else if (!aw_held && !bvalid)
         begin
            awready <= 1'b1;
         end
         if (wvalid && wready)
         begin
            wready <= 1'b0;
            w_held <= 1'b1;
            wdat   <= wdata;
            wstr   <= wstrb;
         end
         else if (!w_held && !bvalid)
         begin
            wready <= 1'b1;
         end
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
         end
      end
   end

   // write response and control register effects
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid     <= 1'b0;
         bresp      <= RESP_OKAY;
         restart_wr <= 1'b0;
         no_topoff  <= CTRL_NOTOP_RESET;
      end
      else
      begin
         restart_wr <= 1'b0;
         if (do_write)
         begin
            bvalid <= 1'b1;
            bresp  <= (waddr[7:2] == CTRL_OFS[7:2]) ? RESP_OKAY : RESP_SLVERR;
            if (waddr[7:2] == CTRL_OFS[7:2] && wstr[0])
            begin
               restart_wr <= wdat[CTRL_RESTART_BIT];
               no_topoff  <= wdat[CTRL_NOTOP_BIT];
            end
         end
         else if (bvalid && bready)
         begin
            bvalid <= 1'b0;
         end
      end
   end

   // reads sample state at the address handshake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= RESP_OKAY;
         case (araddr[7:2])
            CTRL_OFS[7:2]:   rdata <= {30'h0, no_topoff, 1'b0};
            STATUS_OFS[7:2]: rdata <= {23'h0, slope_drop, hist_cnt, sleep, charge_suspend,
                                       level, phase};
            TIMER_OFS[7:2]:  rdata <= charge_secs;
            default:
            begin
               rdata <= 32'h0;
               rresp <= RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid && rready)
      begin
         rvalid <= 1'b0;
      end
      else if (!rvalid)
      begin
         arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   fast_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(phase == PH_FAST && !charge_suspend && !sleep) |-> !charge_current_gate_oe)
      else $error("gate pulled low in fast charge");
   sleep_float_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(sleep) |-> !charge_current_gate_oe && !status_indicator_n_oe)
      else $error("pin driven in low power");
   timer_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
      charge_suspend && !new_cycle && !sleep |=> $stable(charge_secs))
      else $error("timer moved while suspended");
   led_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      charge_suspend && !sleep |=> $stable(status_indicator_n_oe))
      else $error("indicator changed while suspended");
   phase_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      charge_suspend && !sleep && !new_cycle |=> $stable(phase))
      else $error("phase moved while suspended");
   history_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(charge_suspend) |=> hist_cnt == 2'h0)
      else $error("history kept on suspend");
   no_topoff_2c_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(phase == PH_TOPOFF) |-> $past(level) != LVL_HIGH)
      else $error("top-off under 2C setting");
   cutoff_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
      phase == PH_FAST && thermal_cutoff_level && !charge_suspend && !sleep
      && !new_cycle |=> phase != PH_FAST)
      else $error("cutoff did not end fast charge");
   led_fast_a: assert property (@(posedge aclk) disable iff (!aresetn)
      phase == PH_FAST && !charge_suspend && !sleep |=> status_indicator_n_oe)
      else $error("indicator not low in fast charge");

endmodule

// [test/cell_model.sv]
// battery, supply and thermistor comparator model for the bench
`timescale 1ns/10ps
module cell_model (
   input  wire logic       full,                 // cell at charge limit
   input  wire logic       hot,                  // cell overheated
   input  wire logic       asleep,               // cell pulled to sleep level
   input  wire logic       warm,                 // cell warming, small sense drop
   output logic            cell_limit_level,     // above cell limit
   output logic            sleep_threshold,      // above sleep level
   output logic            thermal_cutoff_level, // sense below cutoff
   output logic            hot_fault_level,      // sense below hot fault
   output logic [9:0]      thermistor_sense      // sense code, lower is hotter
);
   // clean comparator levels straight from the cell state
   assign cell_limit_level     = full;
   assign sleep_threshold      = asleep;
   assign thermal_cutoff_level = hot;
   assign hot_fault_level      = hot;
   assign thermistor_sense     = hot ? 10'h040 : (warm ? 10'h1f0 : 10'h200);
endmodule

// [test/tb_battery_charge_phase_control.sv]
// self-checking bench of the charge phase controller
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
   $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module tb_battery_charge_phase_control;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic rready = 0, option_low = 1, option_high = 0, charge_suspend = 0;
   logic full = 0, hot = 0, asleep = 0, cold_fault_level = 0, warm = 0;
   logic [3:0] wstrb = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, d;
   logic [1:0] rs;
   logic awready, wready, bvalid, arready, rvalid, cell_limit_level, sleep_threshold;
   logic thermal_cutoff_level, hot_fault_level, charge_current_gate_oe, status_indicator_n_oe;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [9:0] thermistor_sense;
   int error_cnt = 0, n_tests = 0;

   always #2 aclk = ~aclk;

   cell_model model (.full, .hot, .asleep, .warm, .cell_limit_level, .sleep_threshold,
      .thermal_cutoff_level, .hot_fault_level, .thermistor_sense);

   // shortened counts keep the run to a few thousand cycles
   // time limits stay long, so no phase here ends on timeout
   charge_phase_ctrl #(.SEC_CYCLES(20), .ON_CYCLES(4), .TOPOFF_OFF(8), .TRK_LONG(12),
      .TRK_SHORT(6)) dut (.aclk, .aresetn,
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .option_low,
      .option_high, .cell_limit_level, .sleep_threshold, .thermal_cutoff_level,
      .hot_fault_level, .cold_fault_level, .charge_suspend, .thermistor_sense,
      .charge_current_gate_o(), .charge_current_gate_oe, .status_indicator_n_o(),
      .status_indicator_n_oe);

   // bus tasks: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bit pa, pw;
      @(posedge aclk);
      awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
      wstrb <= 4'hf;
      pa = 1; pw = 1;
      while (pa | pw)
      begin
         @(posedge aclk);
         if (pa && awready === 1'b1) begin pa = 0; awvalid <= 0; end
         if (pw && wready === 1'b1) begin pw = 0; wvalid <= 0; end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      rs = bresp; bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      @(posedge aclk);
      while (arready !== 1'b1) @(posedge aclk);
      arvalid <= 0;
      @(posedge aclk);
      while (rvalid !== 1'b1) @(posedge aclk);
      d = rdata; rs = rresp; rready <= 0;
   endtask
   // length of one run of the gate at level v
   task automatic run(input logic v, output int c);
      c = 0;
      while (charge_current_gate_oe !== v) @(posedge aclk);
      while (charge_current_gate_oe === v) begin c++; @(posedge aclk); end
   endtask
   // one whole float slot then one whole pulled-low slot
   task automatic pat(input int off);
      int c;
      run(1, c);
      run(0, c);
      `CHK(c, 4)
      run(1, c);
      `CHK(c, off)
   endtask

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_start;
      rd(8'h04);
      `CHK(d[3:0], 4'h1)
      `CHK(status_indicator_n_oe, 1'b1)
      option_low <= 0;
      rd(8'h04);
      `CHK(d[3:2], 2'h1)
      option_high <= 1;
      rd(8'h04);
      `CHK(d[3:2], 2'h2)
      option_high <= 0; option_low <= 1;
      rd(8'h0c);
      `CHK({rs, d}, {2'b10, 32'h0})
      $display("start and option decode done");
   endtask
   task automatic t_topoff;
      // first sample stays high, later ones sag: slope ends fast charge
      repeat (500) @(posedge aclk);
      warm <= 1;
      while (status_indicator_n_oe === 1'b1) @(posedge aclk);
      rd(8'h04);
      `CHK(d[1:0], 2'h2)
      `CHK(status_indicator_n_oe, 1'b0)
      pat(8);
      charge_suspend <= 1;
      rd(8'h04);
      `CHK(d[4:0], 5'h12)
      `CHK(status_indicator_n_oe, 1'b0)
      pat(12);
      wr(8'h04, 32'h0);
      `CHK(rs, 2'b10)
      charge_suspend <= 0;
      rd(8'h04);
      `CHK(d[1:0], 2'h2)
      pat(8);
      $display("top-off and suspend done");
   endtask
   task automatic t_end;
      hot <= 1;
      rd(8'h04);
      `CHK(d[1:0], 2'h3)
      pat(12);
      hot <= 0; asleep <= 1; full <= 1;
      repeat (4) @(posedge aclk);
      `CHK({charge_current_gate_oe, status_indicator_n_oe}, 2'b00)
      rd(8'h04);
      `CHK(d[5], 1'b1)
      asleep <= 0;
      pat(12);
      option_low <= 0;
      pat(6);
      // limit falling starts a cycle; phase moves two edges later
      full <= 0;
      repeat (2) @(posedge aclk);
      rd(8'h04);
      `CHK(d[1:0], 2'h1)
      wr(8'h00, 32'h1);
      `CHK(rs, 2'b00)
      $display("cutoff, sleep and restart done");
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // watchdog well beyond the few thousand cycles the scenarios need
   initial
   begin
      #200000;
      error_cnt++;
      complete_run;
   end
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      t_start;
      t_topoff;
      t_end;
      complete_run;
   end
endmodule
